// ==== hdl/parallel_signed_saturating_add.sv ====
`timescale 1ns/1ps
`include "psadd_regs.svh"

// Behaviour
// - word add decoded from opcode fields
// - full 128-bit operands split into lanes
// - eight signed halfword lanes added together
// - halfword overflow writes 0x7FFF
// - halfword underflow writes 0x8000
// - in-range halfword writes low sum bits
// - four signed word lanes added together
// - word overflow 0x7FFFFFFF, in-range low bits
// - word underflow writes 0x80000000
// - no exceptions, saturation only
module parallel_signed_saturating_add #(
   parameter int DATA_W = `PSA_DATA_W,
   parameter int HALF_W = `PSA_HALF_W,
   parameter int WORD_W = `PSA_WORD_W,
   parameter logic [`PSA_SUB_W-1:0] HALF_SUBOP = `PSA_SUB_HALF
) (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_valid,
   input wire logic i_stall,
   input wire logic [`PSA_INSTR_W-1:0] i_instr,
   input wire logic [DATA_W-1:0] i_src_a,
   input wire logic [DATA_W-1:0] i_src_b,
   output logic o_valid,
   output logic o_unknown_op,
   output logic o_half_op,
   output logic o_word_op,
   output logic [DATA_W/HALF_W-1:0] o_sat_mask,
   output logic [DATA_W-1:0] o_result
);

   localparam int HALF_N = DATA_W / HALF_W;
   localparam int WORD_N = DATA_W / WORD_W;
   localparam int HALF_PER_WORD = WORD_W / HALF_W;

   if ((DATA_W % WORD_W) != 0 || WORD_W != 2 * HALF_W || HALF_W < 2) begin : g_bad_geometry
      $error("parallel_signed_saturating_add: lane widths do not tile the register");
   end
   if (HALF_SUBOP == `PSA_SUB_WORD) begin : g_bad_subop
      $error("parallel_signed_saturating_add: halfword sub-op clashes with word sub-op");
   end

   // classify one instruction word; anything outside the two adds is OP_NONE
   function automatic psadd_pkg::lane_op_t decode_op(
      input logic [`PSA_INSTR_W-1:0] instr,
      input logic [`PSA_SUB_W-1:0] half_sub
   );
      logic group_hit;
      logic [`PSA_SUB_W-1:0] sub;
      group_hit = (instr[`PSA_MAJOR_HI:`PSA_MAJOR_LO] == `PSA_MAJOR_OPC) &&
                  (instr[`PSA_FUNC_HI:`PSA_FUNC_LO] == `PSA_FUNC_GRP0);
      sub = instr[`PSA_SUB_HI:`PSA_SUB_LO];
      if (group_hit && sub == `PSA_SUB_WORD) begin
         decode_op = psadd_pkg::OP_WORD;
      end else if (group_hit && sub == half_sub) begin
         decode_op = psadd_pkg::OP_HALF;
      end else begin
         decode_op = psadd_pkg::OP_NONE;
      end
   endfunction

   psadd_pkg::lane_op_t op_dec;
   logic [HALF_W-1:0] half_res [HALF_N];
   logic [HALF_N-1:0] half_over;
   logic [HALF_N-1:0] half_under;
   logic [WORD_W-1:0] word_res [WORD_N];
   logic [WORD_N-1:0] word_over;
   logic [WORD_N-1:0] word_under;

   for (genvar h = 0; h < HALF_N; h++) begin : g_half
      sat_lane_add #(
         .LANE_W(HALF_W)
      ) u_half (
         .i_a(i_src_a[h*HALF_W +: HALF_W]),
         .i_b(i_src_b[h*HALF_W +: HALF_W]),
         .o_sum(half_res[h]),
         .o_over(half_over[h]),
         .o_under(half_under[h])
      );
   end

   for (genvar w = 0; w < WORD_N; w++) begin : g_word
      sat_lane_add #(
         .LANE_W(WORD_W)
      ) u_word (
         .i_a(i_src_a[w*WORD_W +: WORD_W]),
         .i_b(i_src_b[w*WORD_W +: WORD_W]),
         .o_sum(word_res[w]),
         .o_over(word_over[w]),
         .o_under(word_under[w])
      );
   end

   logic valid_reg;
   logic valid_next;
   logic unknown_reg;
   logic unknown_next;
   psadd_pkg::lane_op_t op_reg;
   psadd_pkg::lane_op_t op_next;
   logic [HALF_N-1:0] mask_reg;
   logic [HALF_N-1:0] mask_next;
   logic [DATA_W-1:0] result_reg;
   logic [DATA_W-1:0] result_next;

   always_comb begin
      op_dec = decode_op(i_instr, HALF_SUBOP);
      valid_next = valid_reg;
      unknown_next = unknown_reg;
      op_next = op_reg;
      mask_next = mask_reg;
      result_next = result_reg;
      // a stalled core freezes the stage; the offered instruction is not taken
      if (!i_stall) begin
         valid_next = i_valid && (op_dec != psadd_pkg::OP_NONE);
         unknown_next = i_valid && (op_dec == psadd_pkg::OP_NONE);
         if (i_valid && op_dec == psadd_pkg::OP_HALF) begin
            op_next = op_dec;
            // each lane placed from its own adder only
            for (int h = 0; h < HALF_N; h++) begin
               result_next[h*HALF_W +: HALF_W] = half_res[h];
               mask_next[h] = half_over[h] || half_under[h];
            end
         end else if (i_valid && op_dec == psadd_pkg::OP_WORD) begin
            op_next = op_dec;
            // word lanes tile the full register
            for (int w = 0; w < WORD_N; w++) begin
               result_next[w*WORD_W +: WORD_W] = word_res[w];
               for (int k = 0; k < HALF_PER_WORD; k++) begin
                  mask_next[w*HALF_PER_WORD + k] = word_over[w] || word_under[w];
               end
            end
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         valid_reg <= 1'b0;
         unknown_reg <= 1'b0;
         op_reg <= psadd_pkg::OP_NONE;
         mask_reg <= '0;
         result_reg <= '0;
      end else begin
         valid_reg <= valid_next;
         unknown_reg <= unknown_next;
         op_reg <= op_next;
         mask_reg <= mask_next;
         result_reg <= result_next;
      end
   end

   assign o_valid = valid_reg;
   assign o_unknown_op = unknown_reg;
   assign o_half_op = (op_reg == psadd_pkg::OP_HALF);
   assign o_word_op = (op_reg == psadd_pkg::OP_WORD);
   assign o_sat_mask = mask_reg;
   assign o_result = result_reg;

   // checking helpers: independent wide sums on chosen lanes
   localparam int TOP_H = (HALF_N - 1) * HALF_W;
   localparam int TOP_W = (WORD_N - 1) * WORD_W;

   logic signed [HALF_W:0] chk_half_top;
   logic signed [HALF_W:0] chk_half_low;
   logic signed [WORD_W:0] chk_word_top;
   logic signed [WORD_W:0] chk_word_low;
   logic chk_half_carry;
   logic chk_word_carry;
   logic [HALF_W:0] chk_half_uns;
   logic [WORD_W:0] chk_word_uns;

   always_comb begin
      chk_half_top = $signed({i_src_a[TOP_H+HALF_W-1], i_src_a[TOP_H +: HALF_W]}) +
                     $signed({i_src_b[TOP_H+HALF_W-1], i_src_b[TOP_H +: HALF_W]});
      chk_half_low = $signed({i_src_a[HALF_W-1], i_src_a[HALF_W-1:0]}) +
                     $signed({i_src_b[HALF_W-1], i_src_b[HALF_W-1:0]});
      chk_word_top = $signed({i_src_a[TOP_W+WORD_W-1], i_src_a[TOP_W +: WORD_W]}) +
                     $signed({i_src_b[TOP_W+WORD_W-1], i_src_b[TOP_W +: WORD_W]});
      chk_word_low = $signed({i_src_a[WORD_W-1], i_src_a[WORD_W-1:0]}) +
                     $signed({i_src_b[WORD_W-1], i_src_b[WORD_W-1:0]});
      chk_half_uns = {1'b0, i_src_a[HALF_W-1:0]} + {1'b0, i_src_b[HALF_W-1:0]};
      chk_word_uns = {1'b0, i_src_a[WORD_W-1:0]} + {1'b0, i_src_b[WORD_W-1:0]};
      chk_half_carry = chk_half_uns[HALF_W];
      chk_word_carry = chk_word_uns[WORD_W];
   end

   localparam logic [HALF_W-1:0] HALF_MAX = {1'b0, {(HALF_W-1){1'b1}}};
   localparam logic [HALF_W-1:0] HALF_MIN = {1'b1, {(HALF_W-1){1'b0}}};
   localparam logic [WORD_W-1:0] WORD_MAX = {1'b0, {(WORD_W-1){1'b1}}};
   localparam logic [WORD_W-1:0] WORD_MIN = {1'b1, {(WORD_W-1){1'b0}}};

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_nrst);

   sequence s_take;
      i_valid && !i_stall;
   endsequence

   sequence s_half_take;
      s_take and (op_dec == psadd_pkg::OP_HALF);
   endsequence

   sequence s_word_take;
      s_take and (op_dec == psadd_pkg::OP_WORD);
   endsequence

   sequence s_done_half;
      o_valid && o_half_op && !o_word_op;
   endsequence

   sequence s_done_word;
      o_valid && o_word_op && !o_half_op;
   endsequence

   a_word_decode: assert property (
      s_take and (i_instr[`PSA_MAJOR_HI:`PSA_MAJOR_LO] == `PSA_MAJOR_OPC) and
      (i_instr[`PSA_FUNC_HI:`PSA_FUNC_LO] == `PSA_FUNC_GRP0) and
      (i_instr[`PSA_SUB_HI:`PSA_SUB_LO] == `PSA_SUB_WORD) |=> s_done_word)
      else $error("word add not recognised");

   a_one_lane_kind: assert property (
      s_take |=> (o_valid ? (o_half_op ^ o_word_op) : o_unknown_op))
      else $error("lane kind not unique after issue");

   a_half_top_lane: assert property (
      s_half_take and (chk_half_top[HALF_W] == chk_half_top[HALF_W-1]) |=>
      s_done_half ##0 (o_result[TOP_H +: HALF_W] == $past(chk_half_top[HALF_W-1:0])))
      else $error("top halfword lane misplaced");

   a_half_over: assert property (
      s_half_take and (chk_half_top[HALF_W:HALF_W-1] == 2'h1) |=>
      (o_result[TOP_H +: HALF_W] == HALF_MAX) && o_sat_mask[HALF_N-1])
      else $error("halfword overflow not clamped");

   a_half_under: assert property (
      s_half_take and (chk_half_top[HALF_W:HALF_W-1] == 2'h2) |=>
      (o_result[TOP_H +: HALF_W] == HALF_MIN) && o_sat_mask[HALF_N-1])
      else $error("halfword underflow not clamped");

   a_half_pass: assert property (
      s_half_take and (chk_half_low[HALF_W] == chk_half_low[HALF_W-1]) |=>
      (o_result[HALF_W-1:0] == $past(chk_half_low[HALF_W-1:0])) && !o_sat_mask[0])
      else $error("in-range halfword altered");

   a_word_pass: assert property (
      s_word_take and (chk_word_low[WORD_W] == chk_word_low[WORD_W-1]) |=>
      s_done_word ##0 (o_result[WORD_W-1:0] == $past(chk_word_low[WORD_W-1:0])))
      else $error("in-range word altered");

   a_word_over: assert property (
      s_word_take and (chk_word_top[WORD_W:WORD_W-1] == 2'h1) |=>
      (o_result[TOP_W +: WORD_W] == WORD_MAX) && o_sat_mask[HALF_N-1])
      else $error("word overflow not clamped");

   a_word_under: assert property (
      s_word_take and (chk_word_top[WORD_W:WORD_W-1] == 2'h2) |=>
      (o_result[TOP_W +: WORD_W] == WORD_MIN) && o_sat_mask[HALF_N-1])
      else $error("word underflow not clamped");

   a_never_trap: assert property (
      (s_half_take or s_word_take) |=> o_valid && !o_unknown_op)
      else $error("decoded add failed to complete");

   a_half_no_carry: assert property (
      s_half_take and chk_half_carry and
      (i_src_a[HALF_W +: HALF_W] == '0) and (i_src_b[HALF_W +: HALF_W] == '0) |=>
      o_result[HALF_W +: HALF_W] == '0)
      else $error("carry leaked into halfword lane 1");

   a_word_no_carry: assert property (
      s_word_take and chk_word_carry and
      (i_src_a[WORD_W +: WORD_W] == '0) and (i_src_b[WORD_W +: WORD_W] == '0) |=>
      o_result[WORD_W +: WORD_W] == '0)
      else $error("carry leaked into word lane 1");

   a_stall_hold: assert property (
      i_stall |=> $stable(o_result) && $stable(o_valid) && $stable(o_sat_mask))
      else $error("stage moved during stall");

   // unknown ops must leave the last result for the core to reuse
   a_unknown_hold: assert property (
      s_take and (op_dec == psadd_pkg::OP_NONE) |=>
      o_unknown_op && !o_valid && $stable(o_result) && $stable(o_sat_mask))
      else $error("unknown op disturbed the stage");

   a_pulse_drop: assert property (
      !i_valid && !i_stall |=> !o_valid && !o_unknown_op)
      else $error("completion pulse stretched");

   // checked through reset, so the usual disable is switched off here
   a_reset_clear: assert property (disable iff (1'b0)
      !i_nrst |=> !o_valid && !o_unknown_op && o_result == '0 && o_sat_mask == '0)
      else $error("reset left stage busy");

endmodule

// ==== hdl/psadd_regs.svh ====
`ifndef PSADD_REGS_SVH
`define PSADD_REGS_SVH

// datapath geometry
`define PSA_DATA_W 128
`define PSA_HALF_W 16
`define PSA_WORD_W 32
`define PSA_INSTR_W 32
`define PSA_SUB_W 5

// instruction field positions
`define PSA_MAJOR_HI 31
`define PSA_MAJOR_LO 26
`define PSA_SUB_HI 10
`define PSA_SUB_LO 6
`define PSA_FUNC_HI 5
`define PSA_FUNC_LO 0

// field encodings
`define PSA_MAJOR_OPC 6'h1C
`define PSA_FUNC_GRP0 6'h08
`define PSA_SUB_WORD 5'h10
`define PSA_SUB_HALF 5'h14

`endif

// ==== hdl/psadd_pkg.sv ====
package psadd_pkg;

   typedef enum logic [1:0] {
      OP_NONE = 2'h0,
      OP_HALF = 2'h1,
      OP_WORD = 2'h2
   } lane_op_t;

endpackage

// ==== hdl/sat_lane_add.sv ====
`timescale 1ns/1ps

module sat_lane_add #(
   parameter int LANE_W = 16
) (
   input wire logic [LANE_W-1:0] i_a,
   input wire logic [LANE_W-1:0] i_b,
   output logic [LANE_W-1:0] o_sum,
   output logic o_over,
   output logic o_under
);

   localparam logic [LANE_W-1:0] LANE_MAX = {1'b0, {(LANE_W-1){1'b1}}};
   localparam logic [LANE_W-1:0] LANE_MIN = {1'b1, {(LANE_W-1){1'b0}}};

   if (LANE_W < 2) begin : g_bad_width
      $error("sat_lane_add: lane width below two bits");
   end

   logic [LANE_W-1:0] raw_sum;

   always_comb begin
      raw_sum = i_a + i_b;
      // signs agree going in and differ coming out: the wrapped value is wrong
      o_over = !i_a[LANE_W-1] && !i_b[LANE_W-1] && raw_sum[LANE_W-1];
      o_under = i_a[LANE_W-1] && i_b[LANE_W-1] && !raw_sum[LANE_W-1];
      if (o_over) begin
         o_sum = LANE_MAX;
      end else if (o_under) begin
         o_sum = LANE_MIN;
      end else begin
         o_sum = raw_sum;
      end
   end

endmodule

// ==== testbench/parallel_signed_saturating_add_tb_top.sv ====
`timescale 1ns/1ps

module parallel_signed_saturating_add_tb_top;
   logic i_core_clk;
   logic i_nrst = 1'h0;
   logic i_valid = 1'h0;
   logic i_stall = 1'h0;
   logic [31:0] i_instr = 32'h0000_0000;
   logic [127:0] i_src_a = 128'h0;
   logic [127:0] i_src_b = 128'h0;
   logic o_valid, o_unknown_op, o_half_op, o_word_op;
   logic [7:0] o_sat_mask;
   logic [127:0] o_result;
   int bad_count = 0;
   int checked = 0;
   localparam logic [31:0] WORD_INS = 32'h7000_0408;
   localparam logic [31:0] HALF_INS = 32'h7000_0508;

   parallel_signed_saturating_add parallel_signed_saturating_add_inst (
      .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_valid(i_valid), .i_stall(i_stall),
      .i_instr(i_instr), .i_src_a(i_src_a), .i_src_b(i_src_b), .o_valid(o_valid),
      .o_unknown_op(o_unknown_op), .o_half_op(o_half_op), .o_word_op(o_word_op),
      .o_sat_mask(o_sat_mask), .o_result(o_result));

   initial begin
      i_core_clk = 1'h0;
      forever #12.5 i_core_clk = ~i_core_clk;
   end

   task automatic cmp_bit(input string nm, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s: expected %b, seen %b", nm, e, g);
      end
   endtask

   task automatic cmp_mask(input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected sat_mask: expected %h, seen %h", e, g);
      end
   endtask

   task automatic cmp_data(input logic [127:0] e, input logic [127:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected result: expected %h, seen %h", e, g);
      end
   endtask

   // lane-wise signed saturating sum, lane width w
   function automatic logic [127:0] model(input logic [127:0] a, input logic [127:0] b,
                                          input int w, output logic [7:0] m);
      longint x, y, s, mx, mn;
      logic [127:0] r;
      r = 128'h0;
      m = 8'h00;
      mx = (64'sd1 <<< (w - 1)) - 1;
      mn = -(64'sd1 <<< (w - 1));
      for (int i = 0; i < 128 / w; i++) begin
         x = longint'((a >> (i * w)) & ((128'h1 << w) - 1));
         y = longint'((b >> (i * w)) & ((128'h1 << w) - 1));
         if (x > mx) x = x - (mx + 1) * 2;
         if (y > mx) y = y - (mx + 1) * 2;
         s = x + y;
         if (s > mx || s < mn) begin
            s = (s > mx) ? mx : mn;
            for (int k = 0; k < w / 16; k++) m[i * (w / 16) + k] = 1'h1;
         end
         r = r | ((128'(s) & ((128'h1 << w) - 1)) << (i * w));
      end
      return r;
   endfunction

   task automatic send(input logic [31:0] ins, input logic [127:0] a, input logic [127:0] b);
      @(posedge i_core_clk);
      i_valid <= 1'h1;
      i_instr <= ins;
      i_src_a <= a;
      i_src_b <= b;
   endtask

   task automatic take_idle();
      @(posedge i_core_clk);
      i_valid <= 1'h0;
      #1;
   endtask

   task automatic check_add(input logic [127:0] a, input logic [127:0] b, input logic half);
      logic [7:0] m;
      logic [127:0] r;
      r = model(a, b, half ? 16 : 32, m);
      cmp_bit("valid", 1'h1, o_valid);
      cmp_bit("unknown_op", 1'h0, o_unknown_op);
      cmp_bit("half_op", half, o_half_op);
      cmp_bit("word_op", !half, o_word_op);
      cmp_mask(m, o_sat_mask);
      cmp_data(r, o_result);
   endtask

   localparam logic [127:0] HA = 128'hC000_4000_FFFF_1234_8000_7FFF_8000_7FFF;
   localparam logic [127:0] HB = 128'hC000_4000_0001_0FFF_0000_0000_FFFF_0001;
   localparam logic [127:0] WA = 128'h7FFF_FFFF_8000_0000_FFFF_FFFF_4000_0000;
   localparam logic [127:0] WB = 128'h0000_0001_FFFF_FFFF_0000_0001_3FFF_FFFF;
   localparam logic [127:0] CA = 128'h8000_0000_0000_0000_0000_0000_0000_FFFF;
   localparam logic [127:0] CB = 128'hFFFF_FFFF_0000_0000_0000_0000_0000_0001;
   localparam logic [127:0] DA = 128'h7FFF_0000_0000_0000_0000_0000_FFFF_FFFF;
   localparam logic [127:0] DB = 128'h0001_0000_0000_0000_0000_0000_0000_0001;

   task automatic test_reset();
      cmp_bit("valid", 1'h0, o_valid);
      cmp_bit("half_op", 1'h0, o_half_op);
      cmp_bit("word_op", 1'h0, o_word_op);
      cmp_bit("unknown_op", 1'h0, o_unknown_op);
      cmp_mask(8'h00, o_sat_mask);
      cmp_data(128'h0, o_result);
      $display("test reset done");
   endtask

   task automatic test_back_to_back();
      send(HALF_INS, HA, HB);
      send(WORD_INS, WA, WB);
      #1;
      check_add(HA, HB, 1'h1);
      take_idle();
      check_add(WA, WB, 1'h0);
      send(WORD_INS, HA, HB);
      take_idle();
      check_add(HA, HB, 1'h0);
      @(posedge i_core_clk);
      #1;
      cmp_bit("valid", 1'h0, o_valid);
      $display("test back_to_back done");
   endtask

   task automatic test_unknown_and_stall();
      logic [31:0] bad [3] = '{32'h7000_0428, 32'h6000_0408, 32'h7000_04C8};
      logic [7:0] m;
      logic [127:0] r;
      // last accepted add was the word add of HA and HB
      r = model(HA, HB, 32, m);
      for (int i = 0; i < 3; i++) begin
         send(bad[i], WA, WB);
         take_idle();
         cmp_bit("unknown_op", 1'h1, o_unknown_op);
         cmp_bit("valid", 1'h0, o_valid);
         cmp_data(r, o_result);
         cmp_mask(m, o_sat_mask);
      end
      send(HALF_INS, WA, WB);
      i_stall <= 1'h1;
      repeat (2) @(posedge i_core_clk);
      i_stall <= 1'h0;
      #1;
      cmp_bit("valid", 1'h0, o_valid);
      cmp_bit("word_op", 1'h1, o_word_op);
      cmp_data(r, o_result);
      take_idle();
      check_add(WA, WB, 1'h1);
      $display("test unknown_and_stall done");
   endtask

   task automatic test_sat_carry();
      send(HALF_INS, CA, CB);
      send(WORD_INS, CA, CB);
      #1;
      check_add(CA, CB, 1'h1);
      send(HALF_INS, DA, DB);
      #1;
      check_add(CA, CB, 1'h0);
      send(WORD_INS, DA, DB);
      #1;
      check_add(DA, DB, 1'h1);
      take_idle();
      check_add(DA, DB, 1'h0);
      $display("test sat_carry done");
   endtask

   task automatic close_out();
      $display("checked %0d, bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge i_core_clk);
      i_nrst <= 1'h1;
      #1;
      test_reset();
      test_back_to_back();
      test_unknown_and_stall();
      test_sat_carry();
      close_out();
   end

   // tests take well under a hundred cycles
   initial begin
      #(2000 * 25);
      bad_count++;
      close_out();
   end
endmodule
